// [rtl/csl_map.vh]
// Register map, field positions and timing constants of the status LED encoder
`ifndef CSL_MAP_VH
`define CSL_MAP_VH

// Word offsets on the register bus
`define CSL_ADR_CTRL        8'h00
`define CSL_ADR_STAT        8'h04
`define CSL_ADR_EVT         8'h08
`define CSL_ADR_SCRIPT      8'h0c
`define CSL_ADR_LED         8'h10

// Reset values
`define CSL_CTRL_RST        8'h00
`define CSL_STAT_RST        8'h00
`define CSL_SCRIPT_RST      8'h00

// Control fields
`define CSL_CTRL_MODE_LSB   0
`define CSL_CTRL_MODE_MSB   2
`define CSL_CTRL_MASTER     3

// Mode encodings
`define CSL_MODE_OFF        3'h0
`define CSL_MODE_DP         3'h1
`define CSL_MODE_RTU        3'h2
`define CSL_MODE_ASCII      3'h3
`define CSL_MODE_SCRIPT     3'h4

// Status level fields
`define CSL_ST_CFG_OK       0
`define CSL_ST_READY        1
`define CSL_ST_DP_RUN       2
`define CSL_ST_DP_CFG_BAD   3
`define CSL_ST_DP_STOP      4
`define CSL_ST_BUSY         5
`define CSL_ST_STOPPED      6

// Event fields, write one to fire
`define CSL_EV_EXCEPT       0
`define CSL_EV_NO_REPLY     1
`define CSL_EV_PARITY       2
`define CSL_EV_CHECKSUM     3
`define CSL_EV_BAD_FUNC     4
`define CSL_EV_BAD_ADDR     5
`define CSL_EV_APP_FAIL     6
`define CSL_EV_GOOD_XCHG    7

// Script control fields
`define CSL_SC_LOADING      0
`define CSL_SC_RUNNING      1
`define CSL_SC_HALTED       2
`define CSL_SC_RED          3
`define CSL_SC_GREEN        4

// Indication codes
`define CSL_IND_OFF         4'h0
`define CSL_IND_GREEN       4'h1
`define CSL_IND_RED         4'h2
`define CSL_IND_RED_FAST    4'h3
`define CSL_IND_RED_SLOW    4'h4
`define CSL_IND_RED_ACYC    4'h5
`define CSL_IND_GREEN_FAST  4'h6
`define CSL_IND_RED_SINGLE  4'h7
`define CSL_IND_PASS        4'h8

// Timing, in milliseconds, and the clock rate
`define CSL_CLK_HZ          10000000
`define CSL_T_FAST_HALF_MS  100
`define CSL_T_SLOW_HALF_MS  500
`define CSL_T_ACYC_ON_MS    100
`define CSL_T_ACYC_OFF_MS   500
`define CSL_T_LOAD_OK_MS    500
`define CSL_T_SINGLE_ON_MS  200
`define CSL_T_SINGLE_OFF_MS 1000

`endif

// [rtl/csl_flash.v]
// On/off pattern generator with restart, used for every flashing indication
`timescale 1ns/1ps
module csl_flash
#(
   parameter CW = 24
)
(
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          ce_i,
   input  wire          restart_i,
   input  wire [CW-1:0] on_len_i,
   input  wire [CW-1:0] off_len_i,
   output reg           lit_o
);

   reg [CW-1:0] cnt;

   // Pattern always starts in the lit phase after a restart
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt   <= {CW{1'b0}};
         lit_o <= 1'b1;
      end
      else if (ce_i)
      begin
         if (restart_i)
         begin
            cnt   <= {CW{1'b0}};
            lit_o <= 1'b1;
         end
         else if (cnt >= (lit_o ? on_len_i : off_len_i) - 1'b1)
         begin
            cnt   <= {CW{1'b0}};
            lit_o <= ~lit_o;
         end
         else
         begin
            cnt <= cnt + 1'b1;
         end
      end
   end

endmodule

// [rtl/csl_wb_regs.v]
// Classic Wishbone slave holding control, status, event and script registers
`timescale 1ns/1ps
`include "csl_map.vh"
module csl_wb_regs
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire [7:0]  led_view_i,
   output reg  [7:0]  ctrl_o,
   output reg  [7:0]  stat_o,
   output reg  [7:0]  evt_o,
   output reg  [7:0]  script_o
);

   wire req;
   wire wr;

   // One access per request; ack drops the cycle after it rose
   assign req = cyc_i & stb_i & ~ack_o;
   assign wr  = req & we_i & sel_i[0];

   // Registered ack and read data, one wait state
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         ack_o <= req;
         dat_o <= 32'h0000_0000;
         if (req & ~we_i)
         begin
            case (adr_i)
               `CSL_ADR_CTRL   : dat_o <= {24'h00_0000, ctrl_o};
               `CSL_ADR_STAT   : dat_o <= {24'h00_0000, stat_o};
               `CSL_ADR_SCRIPT : dat_o <= {24'h00_0000, script_o};
               `CSL_ADR_LED    : dat_o <= {24'h00_0000, led_view_i};
               default         : dat_o <= 32'h0000_0000; // Events and holes read zero
            endcase
         end
      end
   end

   // Software writes; event bits are one-cycle pulses
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_o   <= `CSL_CTRL_RST;
         stat_o   <= `CSL_STAT_RST;
         script_o <= `CSL_SCRIPT_RST;
         evt_o    <= 8'h00;
      end
      else if (ce_i)
      begin
         evt_o <= 8'h00;
         if (wr)
         begin
            case (adr_i)
               `CSL_ADR_CTRL   : ctrl_o   <= dat_i[7:0];
               `CSL_ADR_STAT   : stat_o   <= dat_i[7:0];
               `CSL_ADR_EVT    : evt_o    <= dat_i[7:0];
               `CSL_ADR_SCRIPT : script_o <= dat_i[7:0];
               default         : ;
            endcase
         end
      end
   end

endmodule

// [rtl/csl_led_top.v]
// Communication status LED encoder: mode decode, error latch, script start-up, LED drive
//
// Behaviour
// - DP slave: green run, red bad config, red cyclic stop, red acyclic unconfigured
// - Modbus RTU: steady green while configured and ready or exchanging
// - RTU master: slave exception reply sets steady red
// - RTU master: no reply before response timeout sets steady red
// - RTU: parity or checksum fault on a received frame sets steady red
// - RTU slave: unsupported function code from master sets steady red
// - RTU slave: access to nonexistent register or coil sets steady red
// - RTU slave: application late or answering with error sets steady red
// - RTU: red stays until an error-free exchange clears it
// - RTU: dark during initialisation or with invalid configuration
// - ASCII: green flashes at 5 Hz while sending or receiving
// - ASCII: steady green while idle and ready
// - ASCII: red flashes at 5 Hz when configured and stopped
// - ASCII: red flashes at 1 Hz with no configuration
// - ASCII: dark during initialisation
// - Script mode: own encoding when idle, script colours pass while running
// - Script start-up: steady red while the script is located and loaded
// - After a good load: green about 0.5 s, then off before script control
// - Script error or halt: red 200 ms flash, 1000 ms off; green holds
`timescale 1ns/1ps
`include "csl_map.vh"
module csl_led_top
#(
   parameter CLK_HZ    = `CSL_CLK_HZ,
   parameter CW        = 24,
   parameter FAST_HALF = `CSL_T_FAST_HALF_MS * (CLK_HZ / 1000),
   parameter SLOW_HALF = `CSL_T_SLOW_HALF_MS * (CLK_HZ / 1000),
   parameter ACYC_ON   = `CSL_T_ACYC_ON_MS * (CLK_HZ / 1000),
   parameter ACYC_OFF  = `CSL_T_ACYC_OFF_MS * (CLK_HZ / 1000),
   parameter LOAD_OK   = `CSL_T_LOAD_OK_MS * (CLK_HZ / 1000),
   parameter SGL_ON    = `CSL_T_SINGLE_ON_MS * (CLK_HZ / 1000),
   parameter SGL_OFF   = `CSL_T_SINGLE_OFF_MS * (CLK_HZ / 1000)
)
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output wire [31:0] dat_o,
   output wire        ack_o,
   output reg         led_red_o,
   output reg         led_green_o
);

   localparam [CW-1:0] L_FAST     = FAST_HALF;
   localparam [CW-1:0] L_SLOW     = SLOW_HALF;
   localparam [CW-1:0] L_ACYC_ON  = ACYC_ON;
   localparam [CW-1:0] L_ACYC_OFF = ACYC_OFF;
   localparam [CW-1:0] L_LOAD_OK  = LOAD_OK;
   localparam [CW-1:0] L_SGL_ON   = SGL_ON;
   localparam [CW-1:0] L_SGL_OFF  = SGL_OFF;

   // Script start-up states
   localparam [1:0] SS_IDLE  = 2'd0;
   localparam [1:0] SS_LOAD  = 2'd1;
   localparam [1:0] SS_SHOW  = 2'd2;
   localparam [1:0] SS_DONE  = 2'd3;

   wire [7:0]    ctrl;
   wire [7:0]    stat;
   wire [7:0]    evt;
   wire [7:0]    script;
   wire [7:0]    led_view;
   wire [2:0]    mode;
   wire          master;
   wire          cfg_ok;
   wire          ready;
   wire          rtu_err_ev;
   wire          flash_lit;
   wire          restart;

   reg           rtu_err;
   reg  [1:0]    sst;
   reg  [1:0]    next_sst;
   reg  [CW-1:0] show_cnt;
   reg  [3:0]    ind;
   reg  [3:0]    ind_q;
   reg  [CW-1:0] on_len;
   reg  [CW-1:0] off_len;
   reg           next_red;
   reg           next_green;
   reg           green_keep;

   assign mode   = ctrl[`CSL_CTRL_MODE_MSB:`CSL_CTRL_MODE_LSB];
   assign master = ctrl[`CSL_CTRL_MASTER];
   assign cfg_ok = stat[`CSL_ST_CFG_OK];
   assign ready  = stat[`CSL_ST_READY];

   // Bus slave and the software-visible registers
   csl_wb_regs u_regs
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .cyc_i      (cyc_i),
      .stb_i      (stb_i),
      .we_i       (we_i),
      .adr_i      (adr_i),
      .sel_i      (sel_i),
      .dat_i      (dat_i),
      .dat_o      (dat_o),
      .ack_o      (ack_o),
      .led_view_i (led_view),
      .ctrl_o     (ctrl),
      .stat_o     (stat),
      .evt_o      (evt),
      .script_o   (script)
   );

   // Error causes, sorted by role so stray events of the other role are ignored
   assign rtu_err_ev =
      (master & evt[`CSL_EV_EXCEPT]) |
      (master & evt[`CSL_EV_NO_REPLY]) |
      evt[`CSL_EV_PARITY] | evt[`CSL_EV_CHECKSUM] |
      (~master & evt[`CSL_EV_BAD_FUNC]) |
      (~master & evt[`CSL_EV_BAD_ADDR]) |
      (~master & evt[`CSL_EV_APP_FAIL]);

   // Sticky error: a new error in the same cycle as a clean exchange wins
   always @(posedge clk_i)
   begin
      if (rst_i)
         rtu_err <= 1'b0;
      else if (ce_i)
      begin
         if (mode != `CSL_MODE_RTU)
            rtu_err <= 1'b0;
         else if (rtu_err_ev)
            rtu_err <= 1'b1;
         else if (evt[`CSL_EV_GOOD_XCHG])
            rtu_err <= 1'b0;
      end
   end

   // Script start-up sequence: load, green acknowledge, hand-over
   always @*
   begin
      next_sst = sst;
      case (sst)
         SS_IDLE :
            if (script[`CSL_SC_LOADING])
               next_sst = SS_LOAD;
         SS_LOAD :
            if (script[`CSL_SC_HALTED])
               next_sst = SS_IDLE;
            else if (~script[`CSL_SC_LOADING])
               next_sst = SS_SHOW;
         SS_SHOW :
            if (show_cnt >= L_LOAD_OK - 1'b1)
               next_sst = SS_DONE;
         SS_DONE :
            if (script[`CSL_SC_LOADING])
               next_sst = SS_LOAD;
         default : next_sst = SS_IDLE;
      endcase
   end

   // Sequencer state and the 0.5 s acknowledge timer
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sst      <= SS_IDLE;
         show_cnt <= {CW{1'b0}};
      end
      else if (ce_i)
      begin
         if (mode != `CSL_MODE_SCRIPT)
            sst <= SS_IDLE;
         else
            sst <= next_sst;
         if (sst == SS_SHOW)
            show_cnt <= show_cnt + 1'b1;
         else
            show_cnt <= {CW{1'b0}};
      end
   end

   // Indication chosen from mode and status; priorities follow severity
   always @*
   begin
      ind = `CSL_IND_OFF;
      case (mode)
         `CSL_MODE_DP :
         begin
            if (~cfg_ok)
               ind = `CSL_IND_RED_ACYC;
            else if (stat[`CSL_ST_DP_CFG_BAD])
               ind = `CSL_IND_RED;
            else if (stat[`CSL_ST_DP_STOP])
               ind = `CSL_IND_RED_FAST;
            else if (stat[`CSL_ST_DP_RUN])
               ind = `CSL_IND_GREEN;
         end
         `CSL_MODE_RTU :
         begin
            if (~cfg_ok | ~ready)
               ind = `CSL_IND_OFF;
            else if (rtu_err)
               ind = `CSL_IND_RED;
            else
               ind = `CSL_IND_GREEN;
         end
         `CSL_MODE_ASCII :
         begin
            if (~cfg_ok)
               ind = `CSL_IND_RED_SLOW;
            else if (~ready)
               ind = `CSL_IND_OFF;
            else if (stat[`CSL_ST_STOPPED])
               ind = `CSL_IND_RED_FAST;
            else if (stat[`CSL_ST_BUSY])
               ind = `CSL_IND_GREEN_FAST;
            else
               ind = `CSL_IND_GREEN;
         end
         `CSL_MODE_SCRIPT :
         begin
            if (script[`CSL_SC_HALTED])
               ind = `CSL_IND_RED_SINGLE;
            else if (sst == SS_LOAD)
               ind = `CSL_IND_RED;
            else if (sst == SS_SHOW)
               ind = `CSL_IND_GREEN;
            else if (sst == SS_DONE && script[`CSL_SC_RUNNING])
               ind = `CSL_IND_PASS;
            else
               ind = `CSL_IND_OFF;
         end
         default : ind = `CSL_IND_OFF;
      endcase
   end

   // Phase lengths; cyclic patterns use equal halves
   always @*
   begin
      on_len  = L_FAST;
      off_len = L_FAST;
      case (ind)
         `CSL_IND_RED_SLOW :
         begin
            on_len  = L_SLOW;
            off_len = L_SLOW;
         end
         `CSL_IND_RED_ACYC :
         begin
            on_len  = L_ACYC_ON;
            off_len = L_ACYC_OFF;
         end
         `CSL_IND_RED_SINGLE :
         begin
            on_len  = L_SGL_ON;
            off_len = L_SGL_OFF;
         end
         default :
         begin
            on_len  = L_FAST;
            off_len = L_FAST;
         end
      endcase
   end

   // A changed indication always begins with a fresh lit phase
   assign restart = (ind != ind_q);

   csl_flash #(.CW(CW)) u_flash
   (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .restart_i (restart),
      .on_len_i  (on_len),
      .off_len_i (off_len),
      .lit_o     (flash_lit)
   );

   // Colour decode; red wins any overlap so both never light together
   always @*
   begin
      next_red   = 1'b0;
      next_green = 1'b0;
      case (ind)
         `CSL_IND_GREEN      : next_green = 1'b1;
         `CSL_IND_RED        : next_red   = 1'b1;
         `CSL_IND_RED_FAST,
         `CSL_IND_RED_SLOW,
         `CSL_IND_RED_ACYC   : next_red   = flash_lit & ~restart;
         `CSL_IND_GREEN_FAST : next_green = flash_lit & ~restart;
         `CSL_IND_RED_SINGLE :
         begin
            next_red   = flash_lit & ~restart;
            next_green = green_keep & ~next_red;
         end
         `CSL_IND_PASS :
         begin
            next_red   = script[`CSL_SC_RED];
            next_green = script[`CSL_SC_GREEN] & ~script[`CSL_SC_RED];
         end
         default :
         begin
            next_red   = 1'b0;
            next_green = 1'b0;
         end
      endcase
   end

   // LED drive registers; reset blanks both colours
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         led_red_o   <= 1'b0;
         led_green_o <= 1'b0;
         ind_q       <= `CSL_IND_OFF;
         green_keep  <= 1'b0;
      end
      else if (ce_i)
      begin
         led_red_o   <= next_red;
         led_green_o <= next_green;
         ind_q       <= ind;
         if (ind != `CSL_IND_RED_SINGLE)
            green_keep <= next_green; // Frozen during a halt so green returns after each flash
      end
   end

   // Readback of block state
   assign led_view = {led_green_o, led_red_o, rtu_err, sst[0], ind};

endmodule

// [verif/csl_led_chk.sv]
// Port-level assertions for the status LED encoder
`timescale 1ns/1ps
module csl_led_chk
#(
   parameter FAST_HALF = 4,
   parameter SLOW_HALF = 10
)
(
   input wire        clk_i,
   input wire        rst_i,
   input wire        ce_i,
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [7:0]  adr_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   input wire        led_red_o,
   input wire        led_green_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [2:0]  mode;
   logic [7:0]  stat;
   logic [31:0] red_run;
   logic [31:0] age;
   // Shadow copies of mode and status, taken at the write edge
   wire wr = cyc_i && stb_i && we_i && ce_i && !ack_o && sel_i[0];
   wire rtu_on = mode == 3'h2 && stat[1:0] == 2'b11;
   wire fast = mode == 3'h3 && stat[1:0] == 2'b11 && stat[6];
   wire slow = mode == 3'h3 && !stat[0];
   // Age restarts on any write so a flash begun under old settings is not judged
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode <= 3'h0;
         stat <= 8'h00;
         red_run <= 32'h0000_0000;
         age <= 32'h0000_0000;
      end
      else
      begin
         if (wr && adr_i == 8'h00) mode <= dat_i[2:0];
         if (wr && adr_i == 8'h04) stat <= dat_i[7:0];
         red_run <= led_red_o ? red_run + 1 : 32'h0000_0000;
         age <= wr ? 32'h0000_0000 : age + 1;
      end
   end

   a_never_both: assert property (!(led_red_o && led_green_o))
      else $error("both colours lit");
   a_reset_blank: assert property (disable iff (1'b0)
      rst_i && ce_i |=> !led_red_o && !led_green_o && !ack_o)
      else $error("reset did not blank outputs");
   a_ack_next: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
      else $error("no ack one cycle after request");
   a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o && dat_o == 32'h0000_0000)
      else $error("ack or read data held too long");
   a_dp_run: assert property ((mode == 3'h1 && stat[0] && stat[4:2] == 3'b001)[*3]
      |-> led_green_o && !led_red_o)
      else $error("DP run not steady green");
   a_rtu_dark: assert property ((mode == 3'h2 && stat[1:0] != 2'b11)[*3]
      |-> !led_red_o && !led_green_o)
      else $error("RTU not dark while unconfigured");
   a_ascii_dark: assert property ((mode == 3'h3 && stat[1:0] == 2'b01)[*3]
      |-> !led_red_o && !led_green_o)
      else $error("ASCII not dark during init");
   a_err_red: assert property (rtu_on && wr && adr_i == 8'h08 && dat_i[2]
      |-> ##[1:4] led_red_o && !led_green_o)
      else $error("parity fault did not light red");
   a_err_clear: assert property (rtu_on && wr && adr_i == 8'h08 && dat_i[7:0] == 8'h80
      |-> ##[1:4] led_green_o && !led_red_o)
      else $error("clean exchange did not clear red");
   a_fast_half: assert property ($fell(led_red_o) && fast && age > red_run + 3
      |-> red_run == FAST_HALF)
      else $error("fast red flash length wrong");
   a_slow_half: assert property ($fell(led_red_o) && slow && age > red_run + 3
      |-> red_run == SLOW_HALF)
      else $error("slow red flash length wrong");
endmodule

// [verif/csl_led_model.sv]
// Behavioural duo LED watching the encoder drive lines
`timescale 1ns/1ps
module csl_led_model
(
   input  wire clk_i,
   input  wire red_i,
   input  wire green_i,
   output reg  clash_o
);
   // Both dice lit at once would short the duo package; remember it
   initial clash_o = 1'b0;
   always @(posedge clk_i)
   begin
      if (red_i && green_i) clash_o <= 1'b1;
   end
endmodule

// [verif/csl_led_top_tb.sv]
// Self-checking bench for the status LED encoder
`timescale 1ns/1ps
module csl_led_top_tb;
   localparam FH = 4;
   localparam SH = 10;
   localparam AON = 3;
   localparam AOFF = 7;
   localparam LOK = 12;
   localparam SON = 5;
   localparam SOFF = 15;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         ce_i = 1'b1;
   reg         cyc_i = 1'b0;
   reg         stb_i = 1'b0;
   reg         we_i = 1'b0;
   reg  [7:0]  adr_i = 8'h00;
   reg  [3:0]  sel_i = 4'h0;
   reg  [31:0] dat_i = 32'h0000_0000;
   wire [31:0] dat_o;
   wire        ack_o;
   wire        led_red_o;
   wire        led_green_o;
   wire        clash;
   int         error_cnt = 0;
   int         checks = 0;
   int         cycles = 0;

   csl_led_top #(.FAST_HALF(FH), .SLOW_HALF(SH), .ACYC_ON(AON), .ACYC_OFF(AOFF),
      .LOAD_OK(LOK), .SGL_ON(SON), .SGL_OFF(SOFF)) csl_led_top_i (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .led_red_o(led_red_o), .led_green_o(led_green_o));
   csl_led_model csl_led_model_i (.clk_i(clk_i), .red_i(led_red_o),
      .green_i(led_green_o), .clash_o(clash));

   // Clock and hang guard
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         wrap_up;
      end
   end

   task wrap_up;
   begin
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
   begin
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   // One classic cycle; held until ack is sampled high
   task wb(input [7:0] a, input w, input [31:0] d, output [31:0] q);
      int n;
   begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'h1;
      dat_i <= d;
      n = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      chk(32'(ack_o), 32'h0000_0001);
   end
   endtask

   task rd(input [7:0] a, input [31:0] e);
      logic [31:0] q;
   begin
      wb(a, 1'b0, 32'h0000_0000, q);
      chk(q, e);
   end
   endtask

   // Write, then let the two-cycle LED latency pass
   task ws(input [7:0] a, input [31:0] d);
      logic [31:0] q;
   begin
      wb(a, 1'b1, d, q);
      repeat (3) @(posedge clk_i);
   end
   endtask

   task led(input [1:0] e);
      chk({30'h0, led_red_o, led_green_o}, {30'h0, e});
   endtask

   function logic lv(input logic g);
      lv = g ? led_green_o : led_red_o;
   endfunction

   task wt(input g, input v);
      int n;
   begin
      n = 0;
      while (lv(g) !== v && n < 400)
      begin
         @(posedge clk_i);
         n++;
      end
   end
   endtask

   task run(input g, input v, output int n);
   begin
      n = 0;
      while (lv(g) === v && n < 400)
      begin
         @(posedge clk_i);
         n++;
      end
   end
   endtask

   // Lit and dark lengths of one whole flash period
   task meas(input g, input int on_e, input int off_e);
      int on;
      int off;
   begin
      wt(g, 1'b0);
      wt(g, 1'b1);
      run(g, 1'b1, on);
      run(g, 1'b0, off);
      chk(on, on_e);
      chk(off, off_e);
   end
   endtask

   task t_regs;
   begin
      rd(8'h00, 32'h0000_0000);
      rd(8'h0c, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      ws(8'h20, 32'h0000_00ff);
      rd(8'h20, 32'h0000_0000);
      ws(8'h04, 32'h0000_0055);
      rd(8'h04, 32'h0000_0055);
      rd(8'h08, 32'h0000_0000);
      led(2'b00);
   end
   endtask

   task t_dp;
   begin
      ws(8'h00, 32'h0000_0001);
      ws(8'h04, 32'h0000_0000);
      meas(1'b0, AON, AOFF);
      ws(8'h04, 32'h0000_0009);
      led(2'b10);
      ws(8'h04, 32'h0000_0011);
      meas(1'b0, FH, FH);
      ws(8'h04, 32'h0000_0005);
      led(2'b01);
   end
   endtask

   // Each error source sets red, holds it, and a clean exchange clears it
   task t_rtu;
   begin
      ws(8'h00, 32'h0000_000a);
      led(2'b00);
      ws(8'h04, 32'h0000_0003);
      led(2'b01);
      for (int i = 0; i < 7; i++)
      begin
         if (i == 4) ws(8'h00, 32'h0000_0002);
         if (i != 0 && i != 1 || i < 4)
         begin
            ws(8'h08, 32'h0000_0001 << i);
            led(2'b10);
            repeat (20) @(posedge clk_i);
            led(2'b10);
            ws(8'h08, 32'h0000_0080);
            led(2'b01);
         end
      end
      ws(8'h08, 32'h0000_0001);
      led(2'b01);
      ws(8'h08, 32'h0000_0084);
      led(2'b10);
      rd(8'h10, 32'h0000_0062);
      ws(8'h04, 32'h0000_0001);
      led(2'b00);
      ws(8'h04, 32'h0000_0003);
      led(2'b10);
      ws(8'h08, 32'h0000_0080);
      led(2'b01);
   end
   endtask

   task t_ascii;
   begin
      ws(8'h00, 32'h0000_0003);
      ws(8'h04, 32'h0000_0000);
      meas(1'b0, SH, SH);
      ws(8'h04, 32'h0000_0001);
      led(2'b00);
      ws(8'h04, 32'h0000_0043);
      meas(1'b0, FH, FH);
      ws(8'h04, 32'h0000_0023);
      wt(1'b1, 1'b1);
      ce_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      led(2'b01);
      ce_i <= 1'b1;
      meas(1'b1, FH, FH);
      ws(8'h04, 32'h0000_0003);
      led(2'b01);
   end
   endtask

   task t_script;
      int n;
      logic [31:0] q;
   begin
      ws(8'h00, 32'h0000_0004);
      led(2'b00);
      ws(8'h0c, 32'h0000_0001);
      led(2'b10);
      wb(8'h0c, 1'b1, 32'h0000_0000, q);
      wt(1'b1, 1'b1);
      run(1'b1, 1'b1, n);
      chk(n, LOK);
      led(2'b00);
      ws(8'h0c, 32'h0000_0012);
      led(2'b01);
      ws(8'h0c, 32'h0000_000a);
      led(2'b10);
      ws(8'h0c, 32'h0000_001a);
      led(2'b10);
      ws(8'h0c, 32'h0000_0012);
      ws(8'h0c, 32'h0000_0016);
      meas(1'b0, SON, SOFF);
      wt(1'b0, 1'b0);
      led(2'b01);
   end
   endtask

   // Reset in mid-flash must blank everything
   task t_rst;
   begin
      wt(1'b0, 1'b1);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      led(2'b00);
      rd(8'h0c, 32'h0000_0000);
      chk(32'(clash), 32'h0000_0000);
   end
   endtask

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_dp;
      t_rtu;
      t_ascii;
      t_script;
      t_rst;
      wrap_up;
   end
endmodule

bind csl_led_top csl_led_chk #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) csl_led_chk_i
   (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .led_red_o(led_red_o), .led_green_o(led_green_o));
